/* File: hw/itb_interval_timer.sv */
// Interval timer with period and three auxiliary compare channels.
// Assumes synchronous inputs on SYS_CLK and a master that never waits.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps

// Notes on behaviour
// - Batch mode: all buffers load at period match when armed
// - Batch arms only by writing aux register one
// - Second instance: immediate buffer updates only
// - Mode 000 with run set: interval timer
// - Start: FFFF to 0000, toggle zero, load period
// - Period match: clear, toggle zero, period irq
// - Interval is period value plus one ticks
// - Aux match toggles its pin and irq
// - Aux registers writable while running
// - Period zero: counter stays zero, irq each tick
// - Period FFFF: clear with irq, no overflow
// - Immediate period load may wrap through FFFF
// - Aux equal period fires with period irq
// - Aux below period fires once per period
// - Aux above period never matches
// - Immediate mode: buffer follows register write
// - Start or overflow wrap raises no irq
// - Stopped: counter FFFF, count register reads 0
module itb_interval_timer
  import itb_pkg::*;
#(
  parameter int unsigned COUNT_DIV       = 4,
  parameter bit          SECOND_INSTANCE = 1'b0
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RESET_N,
  input  wire itb_bus_req_t       BUS_REQ,
  output logic [CNT_W-1:0]        RDATA,
  output logic                    PERIOD_MATCH_IRQ,
  output logic [NUM_AUX-1:0]      AUX_MATCH_IRQ,
  output logic                    OVERFLOW_IRQ,
  output logic                    TOGGLE_OUT_ZERO,
  output logic [NUM_AUX-1:0]      TOGGLE_OUT_AUX
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int unsigned DIV_W = (COUNT_DIV > 1) ? $clog2(COUNT_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);

  logic [DIV_W-1:0]   div_ff;
  logic               tick_ff;
  logic               run_enable_bit_ff;
  logic [2:0]         mode_field_ff;
  logic               batch_sel_ff;
  logic [CNT_W-1:0]   period_compare_reg_ff;
  logic [CNT_W-1:0]   aux_compare_reg_ff [NUM_AUX];
  logic [CNT_W-1:0]   period_buffer_ff;
  logic [CNT_W-1:0]   aux_buffer_ff      [NUM_AUX];
  logic [CNT_W-1:0]   count_ff;
  logic [CNT_W-1:0]   nxt_count;
  itb_state_t         state_ff;
  logic               armed_ff;
  logic               overflow_flag_ff;
  logic               run_go;
  logic               start_tick;
  logic               period_hit;
  logic [NUM_AUX-1:0] aux_hit;
  logic               wr_period;
  logic [NUM_AUX-1:0] wr_aux;
  logic               batch_on;
  logic               transfer;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic cmp_hit(input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] buf_val,
                                   input logic             tk,
                                   input logic             running);
    cmp_hit = tk && running && (cnt == buf_val);
  endfunction

  function automatic logic is_wr(input itb_bus_req_t req, input logic [ADDR_W-1:0] idx);
    is_wr = req.wr && (req.addr == idx);
  endfunction

  // ----------------------------------------------------------------
  // Count clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      div_ff  <= DIV_ZERO;
      tick_ff <= 1'b0;
    end else if (div_ff == DIV_LAST) begin
      div_ff  <= DIV_ZERO;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + DIV_ONE;
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign run_go     = run_enable_bit_ff && (mode_field_ff == MODE_INTERVAL);
  assign start_tick = tick_ff && run_go && (state_ff == ST_IDLE);
  assign period_hit = cmp_hit(count_ff, period_buffer_ff, tick_ff, run_go && (state_ff == ST_RUN));
  assign wr_period  = is_wr(BUS_REQ, REG_PERIOD);
  assign wr_aux[0]  = is_wr(BUS_REQ, REG_AUX1);
  assign wr_aux[1]  = is_wr(BUS_REQ, REG_AUX2);
  assign wr_aux[2]  = is_wr(BUS_REQ, REG_AUX3);
  assign batch_on   = batch_sel_ff && !SECOND_INSTANCE;
  assign transfer   = period_hit && batch_on && armed_ff;

  for (genvar b = 0; b < NUM_AUX; b++) begin : g_hit
    assign aux_hit[b] = cmp_hit(count_ff, aux_buffer_ff[b], tick_ff,
                                run_go && (state_ff == ST_RUN));
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      run_enable_bit_ff <= 1'b0;
      mode_field_ff     <= MODE_INTERVAL;
      batch_sel_ff      <= 1'b0;
    end else if (is_wr(BUS_REQ, REG_CTRL)) begin
      run_enable_bit_ff <= BUS_REQ.wdata[CTRL_RUN_BIT];
      mode_field_ff     <= BUS_REQ.wdata[CTRL_MODE_MSB:CTRL_MODE_LSB];
      batch_sel_ff      <= BUS_REQ.wdata[CTRL_BATCH_BIT] && !SECOND_INSTANCE;
    end
  end

  // ----------------------------------------------------------------
  // Compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      period_compare_reg_ff <= CMP_RESET;
      for (int b = 0; b < NUM_AUX; b++) begin
        aux_compare_reg_ff[b] <= CMP_RESET;
      end
    end else begin
      if (wr_period) begin
        period_compare_reg_ff <= BUS_REQ.wdata;
      end
      for (int b = 0; b < NUM_AUX; b++) begin
        if (wr_aux[b]) begin
          aux_compare_reg_ff[b] <= BUS_REQ.wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Batch arming
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      armed_ff <= 1'b0;
    end else if (wr_aux[0] && batch_on) begin
      armed_ff <= 1'b1;
    end else if (transfer || !batch_on) begin
      armed_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Buffer registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      period_buffer_ff <= CMP_RESET;
      for (int b = 0; b < NUM_AUX; b++) begin
        aux_buffer_ff[b] <= CMP_RESET;
      end
    end else if (start_tick || transfer) begin
      period_buffer_ff <= period_compare_reg_ff;
      for (int b = 0; b < NUM_AUX; b++) begin
        aux_buffer_ff[b] <= aux_compare_reg_ff[b];
      end
    end else if (!batch_on) begin
      if (wr_period) begin
        period_buffer_ff <= BUS_REQ.wdata;
      end
      for (int b = 0; b < NUM_AUX; b++) begin
        if (wr_aux[b]) begin
          aux_buffer_ff[b] <= BUS_REQ.wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and run state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    if (!run_go) begin
      nxt_count = CNT_IDLE;
    end else if (start_tick) begin
      nxt_count = CNT_ZERO;
    end else if (period_hit) begin
      nxt_count = CNT_ZERO;
    end else if (tick_ff) begin
      nxt_count = count_ff + CNT_ONE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      count_ff <= CNT_IDLE;
      state_ff <= ST_IDLE;
    end else begin
      count_ff <= nxt_count;
      unique case (state_ff)
        ST_IDLE: begin
          if (start_tick) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_go) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pulses and toggle outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      PERIOD_MATCH_IRQ <= 1'b0;
      AUX_MATCH_IRQ    <= '0;
      OVERFLOW_IRQ     <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else begin
      PERIOD_MATCH_IRQ <= period_hit;
      AUX_MATCH_IRQ    <= aux_hit;
      OVERFLOW_IRQ     <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      TOGGLE_OUT_ZERO <= 1'b0;
      TOGGLE_OUT_AUX  <= '0;
    end else begin
      if (start_tick || period_hit) begin
        TOGGLE_OUT_ZERO <= !TOGGLE_OUT_ZERO;
      end
      TOGGLE_OUT_AUX <= TOGGLE_OUT_AUX ^ aux_hit;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      RDATA <= RD_ZERO;
    end else if (BUS_REQ.rd) begin
      RDATA <= RD_ZERO;
      unique case (BUS_REQ.addr)
        REG_CTRL: begin
          RDATA[CTRL_RUN_BIT]                 <= run_enable_bit_ff;
          RDATA[CTRL_MODE_MSB:CTRL_MODE_LSB]  <= mode_field_ff;
          RDATA[CTRL_BATCH_BIT]               <= batch_sel_ff;
        end
        REG_PERIOD: begin
          RDATA <= period_compare_reg_ff;
        end
        REG_AUX1: begin
          RDATA <= aux_compare_reg_ff[0];
        end
        REG_AUX2: begin
          RDATA <= aux_compare_reg_ff[1];
        end
        REG_AUX3: begin
          RDATA <= aux_compare_reg_ff[2];
        end
        REG_COUNT: begin
          RDATA <= run_go ? count_ff : RD_ZERO;
        end
        REG_STATUS: begin
          RDATA[STAT_OVF_BIT] <= overflow_flag_ff;
          RDATA[STAT_ARM_BIT] <= armed_ff;
          RDATA[STAT_RUN_BIT] <= (state_ff == ST_RUN);
        end
        default: begin
          RDATA <= RD_ZERO;
        end
      endcase
    end else begin
      RDATA <= RD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_start;
    start_tick;
  endsequence

  sequence s_wrapped;
    (count_ff == CNT_ZERO) && !PERIOD_MATCH_IRQ && (TOGGLE_OUT_ZERO != $past(TOGGLE_OUT_ZERO));
  endsequence

  chk_batch_only_match: assert property (
    batch_on && (state_ff == ST_RUN) && !transfer |=> $stable(aux_buffer_ff[1]) && $stable(period_buffer_ff)
  ) else $error("Buffer changed in batch mode without a transfer");

  chk_batch_unarmed: assert property (
    period_hit && batch_on && !armed_ff |=> $stable(period_buffer_ff) && $stable(aux_buffer_ff[0])
  ) else $error("Batch transfer taken while not armed");

  chk_second_inst: assert property (
    SECOND_INSTANCE |-> !batch_on && !armed_ff
  ) else $error("Batch mode active on second instance");

  chk_start_wrap: assert property (
    s_start |=> s_wrapped
  ) else $error("Start did not wrap counter quietly with toggle");

  chk_period_clear: assert property (
    period_hit |=> (count_ff == CNT_ZERO) && PERIOD_MATCH_IRQ
  ) else $error("Period match did not clear and interrupt");

  chk_zero_period: assert property (
    (state_ff == ST_RUN) && run_go && (period_buffer_ff == CNT_ZERO) && (count_ff == CNT_ZERO) && tick_ff
      |=> (count_ff == CNT_ZERO) && PERIOD_MATCH_IRQ
  ) else $error("Zero period did not fire every tick");

  chk_aux_match: assert property (
    aux_hit[1] |=> AUX_MATCH_IRQ[1] && (TOGGLE_OUT_AUX[1] != $past(TOGGLE_OUT_AUX[1]))
  ) else $error("Aux match did not toggle and interrupt");

  chk_no_overflow: assert property (
    !OVERFLOW_IRQ && !overflow_flag_ff
  ) else $error("Overflow raised in interval mode");

  chk_stop_rest: assert property (
    !run_go |=> (count_ff == CNT_IDLE) && !PERIOD_MATCH_IRQ ##1 !PERIOD_MATCH_IRQ || run_go
  ) else $error("Stopped counter not resting at all ones");

  chk_imm_load: assert property (
    wr_period && !batch_on && !start_tick |=> period_buffer_ff == $past(BUS_REQ.wdata)
  ) else $error("Immediate write did not reach period buffer");

endmodule // itb_interval_timer

/* File: hw/itb_pkg.sv */
// Package of the interval timer: register map, control fields, reset values.
// Assumes a plain one-cycle register port driven by a synchronous master.
package itb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned NUM_AUX = 3;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h1;
  localparam logic [ADDR_W-1:0] REG_AUX1   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_AUX2   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_AUX3   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_MODE_LSB  = 1;
  localparam int unsigned CTRL_MODE_MSB  = 3;
  localparam int unsigned CTRL_BATCH_BIT = 4;
  localparam int unsigned STAT_OVF_BIT   = 0;
  localparam int unsigned STAT_ARM_BIT   = 1;
  localparam int unsigned STAT_RUN_BIT   = 2;

  localparam logic [2:0] MODE_INTERVAL = 3'h0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_IDLE   = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
  localparam logic [CNT_W-1:0] CMP_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0] RD_ZERO    = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0]  wdata;
    logic              wr;
    logic              rd;
  } itb_bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } itb_state_t;

endpackage

/* File: bench/itb_pin_monitor.sv */
// Pin-side model: counts interrupt pulses and toggle edges of one timer.
// Assumes registered one-cycle irq pulses and level toggle outputs.
`timescale 1ns/10ps

module itb_pin_monitor
  import itb_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               per_irq,
  input  wire logic [NUM_AUX-1:0] aux_irq,
  input  wire logic               ovf_irq,
  input  wire logic               tog0,
  input  wire logic [NUM_AUX-1:0] tog_aux,
  output logic [15:0]             cnt [0:9],
  output logic [31:0]             gap
);
  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  logic [31:0]        cyc_ff;
  logic [31:0]        last_ff;
  logic               tog0_d_ff;
  logic [NUM_AUX-1:0] togaux_d_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_ff <= 32'h0;
      last_ff <= 32'h0;
      gap <= 32'h0;
      tog0_d_ff <= 1'b0;
      togaux_d_ff <= '0;
      for (int i = 0; i < 10; i++) cnt[i] <= 16'h0;
    end else begin
      cyc_ff <= cyc_ff + 32'h1;
      tog0_d_ff <= tog0;
      togaux_d_ff <= tog_aux;
      if (per_irq) begin
        gap <= cyc_ff - last_ff;
        last_ff <= cyc_ff;
        cnt[0] <= cnt[0] + 16'h1;
      end
      if (tog0 != tog0_d_ff) cnt[4] <= cnt[4] + 16'h1;
      if (per_irq && aux_irq[0]) cnt[8] <= cnt[8] + 16'h1;
      if (ovf_irq) cnt[9] <= cnt[9] + 16'h1;
      for (int i = 0; i < NUM_AUX; i++) begin
        if (aux_irq[i]) cnt[1+i] <= cnt[1+i] + 16'h1;
        if (tog_aux[i] != togaux_d_ff[i]) cnt[5+i] <= cnt[5+i] + 16'h1;
      end
    end
  end
endmodule // itb_pin_monitor

/* File: bench/itb_interval_timer_tb_top.sv */
// Testbench of the interval timer: register port driver and pin checks.
// Assumes the design package and a second instance sharing the bus.
`timescale 1ns/10ps

module itb_interval_timer_tb_top;
  import itb_pkg::*;
  localparam int unsigned DIV = 2;

  logic               SYS_CLK;
  logic               RESET_N;
  itb_bus_req_t       bus_req;
  logic [CNT_W-1:0]   rdata;
  logic               per_irq;
  logic               ovf_irq;
  logic               tog0;
  logic [2:0]         aux_irq;
  logic [2:0]         tog_aux;
  logic               per2;
  logic               ovf2;
  logic               tog02;
  logic [2:0]         aux2;
  logic [2:0]         togaux2;
  logic [15:0]        mcnt [0:9];
  logic [15:0]        mcnt2 [0:9];
  logic [15:0]        snap [0:9];
  logic [31:0]        gap;
  logic [31:0]        gap2;
  logic [31:0]        seed;
  logic [15:0]        d;
  logic [15:0]        p;
  int                 mismatches;
  int                 n_tests;

  itb_interval_timer #(.COUNT_DIV(DIV), .SECOND_INSTANCE(1'b0)) dut_u (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .BUS_REQ(bus_req), .RDATA(rdata),
    .PERIOD_MATCH_IRQ(per_irq), .AUX_MATCH_IRQ(aux_irq), .OVERFLOW_IRQ(ovf_irq),
    .TOGGLE_OUT_ZERO(tog0), .TOGGLE_OUT_AUX(tog_aux));
  itb_interval_timer #(.COUNT_DIV(DIV), .SECOND_INSTANCE(1'b1)) dut2_u (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .BUS_REQ(bus_req), .RDATA(),
    .PERIOD_MATCH_IRQ(per2), .AUX_MATCH_IRQ(aux2), .OVERFLOW_IRQ(ovf2),
    .TOGGLE_OUT_ZERO(tog02), .TOGGLE_OUT_AUX(togaux2));
  itb_pin_monitor mon_u (.clk(SYS_CLK), .rst_n(RESET_N), .per_irq(per_irq), .aux_irq(aux_irq),
    .ovf_irq(ovf_irq), .tog0(tog0), .tog_aux(tog_aux), .cnt(mcnt), .gap(gap));
  itb_pin_monitor mon2_u (.clk(SYS_CLK), .rst_n(RESET_N), .per_irq(per2), .aux_irq(aux2),
    .ovf_irq(ovf2), .tog0(tog02), .tog_aux(togaux2), .cnt(mcnt2), .gap(gap2));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chkd(input int i, input logic [15:0] exp);
    chk($sformatf("events_%0d", i), mcnt[i] - snap[i], exp);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    @(posedge SYS_CLK);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge SYS_CLK);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    @(posedge SYS_CLK);
    bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge SYS_CLK);
    bus_req <= '0;
    #1;
    v = rdata;
  endtask

  task automatic wait_irq(input int n);
    int k;
    repeat (n) begin
      for (k = 0; k < 2000; k++) begin
        @(posedge SYS_CLK);
        #1;
        if (per_irq === 1'b1) break;
      end
      if (k == 2000) begin
        mismatches++;
        complete_run();
      end
    end
    @(posedge SYS_CLK);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    RESET_N = 1'b0;
    bus_req = '0;
    mismatches = 0;
    n_tests = 0;
    seed = 32'h8b44;
    repeat (16) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    #1;
    chk("tog0_reset", {15'h0, tog0}, 16'h0);
    rd(REG_COUNT, d);
    chk("count_idle", d, 16'h0);
    rd(4'hf, d);
    chk("unmapped", d, 16'h0);
    // Aux equal, below and above the period
    p = 16'h2 + 16'(rnd() % 6);
    wr(REG_PERIOD, p);
    wr(REG_AUX1, p);
    wr(REG_AUX2, 16'(rnd() % p));
    wr(REG_AUX3, p + 16'h1);
    snap = mcnt;
    wr(REG_CTRL, 16'h1);
    wait_irq(1);
    chkd(4, 16'h2);
    chkd(0, 16'h1);
    snap = mcnt;
    wait_irq(4);
    chk("gap", 16'(gap), 16'((p + 1) * DIV));
    chkd(0, 16'h4);
    chkd(4, 16'h4);
    chkd(8, 16'h4);
    chkd(5, 16'h4);
    chkd(2, 16'h4);
    chkd(6, 16'h4);
    chkd(3, 16'h0);
    chkd(7, 16'h0);
    // Aux rewrite while running
    wr(REG_AUX3, p >> 1);
    wait_irq(1);
    snap = mcnt;
    wait_irq(2);
    chkd(3, 16'h2);
    // Stop: count reads 0, no period or toggle events
    wr(REG_CTRL, 16'h0);
    rd(REG_COUNT, d);
    chk("count_stop", d, 16'h0);
    snap = mcnt;
    repeat (20) @(posedge SYS_CLK);
    #1;
    chkd(0, 16'h0);
    chkd(4, 16'h0);
    // Run set with a mode other than interval, then period zero
    wr(REG_CTRL, 16'h3);
    repeat (20) @(posedge SYS_CLK);
    #1;
    chkd(0, 16'h0);
    chkd(4, 16'h0);
    rd(REG_COUNT, d);
    chk("count_mode", d, 16'h0);
    rd(REG_STATUS, d);
    chk("run_mode", {15'h0, d[STAT_RUN_BIT]}, 16'h0);
    wr(REG_PERIOD, 16'h0);
    for (int i = 0; i < NUM_AUX; i++) wr(ADDR_W'(REG_AUX1 + i), 16'hffff);
    wr(REG_CTRL, 16'h1);
    wait_irq(1);
    snap = mcnt;
    wait_irq(3);
    chk("gap_zero", 16'(gap), 16'(DIV));
    chkd(4, 16'h3);
    chkd(1, 16'h0);
    rd(REG_COUNT, d);
    chk("count_zero", d, 16'h0);
    rd(REG_STATUS, d);
    chk("ovf_flag", {15'h0, d[STAT_OVF_BIT]}, 16'h0);
    chk("running", {15'h0, d[STAT_RUN_BIT]}, 16'h1);
    // Batch transfer
    wr(REG_CTRL, 16'h0);
    wr(REG_PERIOD, 16'h3);
    wr(REG_AUX1, 16'h3);
    wr(REG_CTRL, 16'h11);
    wait_irq(2);
    chk("gap_b0", 16'(gap), 16'(4 * DIV));
    wr(REG_PERIOD, 16'h5);
    wait_irq(5);
    chk("gap_b1", 16'(gap), 16'(4 * DIV));
    chk("gap_inst2", 16'(gap2), 16'(6 * DIV));
    wr(REG_AUX1, 16'h3);
    rd(REG_STATUS, d);
    chk("armed", {15'h0, d[STAT_ARM_BIT]}, 16'h1);
    wait_irq(3);
    chk("gap_b2", 16'(gap), 16'(6 * DIV));
    rd(REG_STATUS, d);
    chk("disarmed", {15'h0, d[STAT_ARM_BIT]}, 16'h0);
    chk("ovf_irq", mcnt[9], 16'h0);
    chk("ovf_irq2", mcnt2[9], 16'h0);
    complete_run();
  end
endmodule // itb_interval_timer_tb_top
